/* File: src/capture_src.sv */
// capture source: picks the capture event for the selected sensor
`timescale 1ns/1ns
`default_nettype none
module capture_src (
  // clock and reset
  input  wire logic        clk,
  input  wire logic        rst,
  // sensor inputs
  input  wire logic        tacho_in,
  input  wire logic        rtc_pulse,
  input  wire logic        timer_high_rd,
  // configuration
  input  wire logic [1:0]  sensor_type_select,
  input  wire logic        edge_direction_bit,
  input  wire logic        encoder_capture_select,
  // event out
  output logic             cap_evt
);

  logic tacho_q;
  logic rise;
  logic fall;
  logic tacho_edge;
  logic hall_edge;
  logic enc_evt;

  // ==========================================================
  // edge detection on the tacho or hall input
  assign rise       = tacho_in && !tacho_q;
  assign fall       = !tacho_in && tacho_q;
  assign tacho_edge = edge_direction_bit ? fall : rise;
  assign hall_edge  = rise || fall;
  assign enc_evt    = encoder_capture_select ? timer_high_rd : rtc_pulse;
  assign cap_evt    = (sensor_type_select == speed_meas_pkg::SENS_TACHO) ? tacho_edge
                    : (sensor_type_select == speed_meas_pkg::SENS_HALL)  ? hall_edge
                    : (sensor_type_select == speed_meas_pkg::SENS_ENC)   ? enc_evt
                    : 1'b0;

  // previous input level
  always_ff @(posedge clk)
  begin
    if (rst)
      tacho_q <= 1'b0;
    else
      tacho_q <= tacho_in;
  end

endmodule : capture_src
`default_nettype wire

/* File: src/prescale_div.sv */
// prescaler: divides source pulses by two to the power of the prescale field
`timescale 1ns/1ns
`default_nettype none
module prescale_div (
  // clock and reset
  input  wire logic                       clk,
  input  wire logic                       rst,
  // source and setting
  input  wire logic                       src_pulse,
  input  wire logic                       run,
  input  wire speed_meas_pkg::prescale_t  prescale,
  // divided tick
  output logic                            tick
);

  logic [14:0] div_q;
  logic [14:0] div_d;
  logic [14:0] div_top;

  // ==========================================================
  // terminal count of the divider
  assign div_top = 15'((16'h0001 << prescale) - 16'h0001);
  // at or above the top so a lowered prescale cannot strand the divider
  assign tick    = run && src_pulse && (div_q >= div_top);
  assign div_d   = !run ? 15'h0000 : tick ? 15'h0000 : src_pulse ? div_q + 15'h0001 : div_q;

  // divider state
  always_ff @(posedge clk)
  begin
    if (rst)
      div_q <= 15'h0000;
    else
      div_q <= div_d;
  end

endmodule : prescale_div
`default_nettype wire

/* File: src/speed_meas_pkg.sv */
// speed measurement timer: shared constants, types and register map
package speed_meas_pkg;

  // ==========================================================
  // widths and carriers
  localparam int ADDR_W = 4;
  typedef logic [ADDR_W-1:0] addr_t;
  typedef logic [7:0]        byte_t;
  typedef logic [15:0]       count_t;
  typedef logic [3:0]        prescale_t;

  typedef struct packed {
    addr_t addr;
    byte_t wdata;
    logic  wr;
    logic  rd;
  } bus_req_s;

  typedef struct packed {
    logic emerg;
    logic speed_err;
    logic capture;
    logic ratio_up;
    logic ratio_down;
  } irq_flags_s;

  typedef struct packed {
    logic emerg;
    logic speed_err;
    logic capture;
    logic ratio;
  } irq_mask_s;

  typedef enum {MODE_CFG, MODE_SWITCHED, MODE_AUTO, MODE_SPEED} mode_e;

  // ==========================================================
  // register offsets
  localparam addr_t ADDR_TIMER_HIGH = 4'h0;
  localparam addr_t ADDR_TIMER_LOW  = 4'h1;
  localparam addr_t ADDR_CAP_HIGH   = 4'h2;
  localparam addr_t ADDR_CAP_LOW    = 4'h3;
  localparam addr_t ADDR_COMM_CMP   = 4'h4;
  localparam addr_t ADDR_SPEED_CMP  = 4'h5;
  localparam addr_t ADDR_PRESCALE   = 4'h6;
  localparam addr_t ADDR_CTRL_A     = 4'h7;
  localparam addr_t ADDR_CTRL_B     = 4'h8;
  localparam addr_t ADDR_ZERO_FILT  = 4'h9;
  localparam addr_t ADDR_IRQ_STATUS = 4'ha;
  localparam addr_t ADDR_IRQ_MASK   = 4'hb;

  // ==========================================================
  // field positions
  localparam int BIT_CLK_EN    = 0;
  localparam int BIT_SENS_LO   = 0;
  localparam int BIT_SENS_HI   = 1;
  localparam int BIT_AUTO_SW   = 2;
  localparam int BIT_EDGE_DIR  = 3;
  localparam int BIT_ENC_CAP   = 0;
  localparam int BIT_RATIO_DN  = 0;
  localparam int BIT_RATIO_UP  = 1;

  // ==========================================================
  // reset values and fixed figures
  localparam byte_t     BYTE_RST    = 8'h00;
  localparam count_t    COUNT_RST   = 16'h0000;
  localparam count_t    COUNT_MAX   = 16'hffff;
  localparam count_t    COUNT_LOW   = 16'h5500;
  localparam byte_t     CMP_LOW     = 8'hff;
  localparam prescale_t PRESCALE_MIN = 4'h0;
  localparam prescale_t PRESCALE_MAX = 4'hf;
  localparam logic [1:0] SENS_NONE  = 2'h0;
  localparam logic [1:0] SENS_TACHO = 2'h1;
  localparam logic [1:0] SENS_HALL  = 2'h2;
  localparam logic [1:0] SENS_ENC   = 2'h3;

endpackage : speed_meas_pkg

/* File: src/speed_meas_timer.sv */
// speed measurement timer with auto prescaler, capture and register port
`timescale 1ns/1ns
`default_nettype none
module speed_meas_timer (
  // clock and reset
  input  wire logic                         clk,
  input  wire logic                         rst,
  // register port
  input  wire speed_meas_pkg::bus_req_s     req,
  output logic [7:0]                        rdata,
  // sensor inputs
  input  wire logic                         tacho_in,
  input  wire logic                         encoder_pulse,
  input  wire logic                         rtc_pulse,
  input  wire logic                         emergency_stop_input,
  // interrupt requests
  output logic                              ratio_irq,
  output logic                              capture_irq,
  output logic                              safety_irq
);

  // ==========================================================
  // registers
  speed_meas_pkg::count_t     cnt_q;
  speed_meas_pkg::count_t     cnt_d;
  speed_meas_pkg::count_t     cap_q;
  speed_meas_pkg::count_t     cap_d;
  speed_meas_pkg::prescale_t  st_q;
  speed_meas_pkg::prescale_t  st_d;
  speed_meas_pkg::byte_t      comm_cmp_q;
  speed_meas_pkg::byte_t      speed_cmp_q;
  speed_meas_pkg::byte_t      ctrl_a_q;
  speed_meas_pkg::byte_t      ctrl_b_q;
  speed_meas_pkg::byte_t      zero_filt_q;
  speed_meas_pkg::irq_flags_s flags_q;
  speed_meas_pkg::irq_flags_s flags_d;
  speed_meas_pkg::irq_mask_s  mask_q;
  logic                       lock_q;
  logic                       lock_d;
  logic [7:0]                 rdata_q;

  // ==========================================================
  // decoded controls
  speed_meas_pkg::mode_e mode;
  logic [1:0]            sensor_type_select;
  logic                  auto_switch_select;
  logic                  clock_enable;
  logic                  edge_direction_bit;
  logic                  encoder_capture_select;
  logic                  speed_mode;
  logic                  is_encoder;
  logic                  src_pulse;
  logic                  tick;
  logic                  cap_evt;
  logic                  cap_take;
  logic                  up_set;
  logic                  down_set;
  logic                  speed_err_hit;
  speed_meas_pkg::count_t err_limit;
  logic [4:0]            clr_bits;
  logic [7:0]            rd_mux;

  // address hit for one register
  function automatic logic hit(input speed_meas_pkg::addr_t a, input speed_meas_pkg::addr_t k);
    hit = (a == k);
  endfunction : hit

  logic wr_timer_high;
  logic wr_timer_low;
  logic wr_cap_high;
  logic wr_cap_low;
  logic wr_comm;
  logic wr_speed;
  logic wr_prescale;
  logic wr_ctrl_a;
  logic wr_ctrl_b;
  logic wr_zero;
  logic wr_status;
  logic wr_mask;
  logic rd_timer_high;
  logic rd_cap_high;
  logic rd_cap_low;

  // write strobes per register, read strobes for timer high and the two capture bytes
  assign wr_timer_high = req.wr && hit(req.addr, speed_meas_pkg::ADDR_TIMER_HIGH);
  assign wr_timer_low  = req.wr && hit(req.addr, speed_meas_pkg::ADDR_TIMER_LOW);
  assign wr_cap_high   = req.wr && hit(req.addr, speed_meas_pkg::ADDR_CAP_HIGH);
  assign wr_cap_low    = req.wr && hit(req.addr, speed_meas_pkg::ADDR_CAP_LOW);
  assign wr_comm       = req.wr && hit(req.addr, speed_meas_pkg::ADDR_COMM_CMP);
  assign wr_speed      = req.wr && hit(req.addr, speed_meas_pkg::ADDR_SPEED_CMP);
  assign wr_prescale   = req.wr && hit(req.addr, speed_meas_pkg::ADDR_PRESCALE);
  assign wr_ctrl_a     = req.wr && hit(req.addr, speed_meas_pkg::ADDR_CTRL_A);
  assign wr_ctrl_b     = req.wr && hit(req.addr, speed_meas_pkg::ADDR_CTRL_B);
  assign wr_zero       = req.wr && hit(req.addr, speed_meas_pkg::ADDR_ZERO_FILT);
  assign wr_status     = req.wr && hit(req.addr, speed_meas_pkg::ADDR_IRQ_STATUS);
  assign wr_mask       = req.wr && hit(req.addr, speed_meas_pkg::ADDR_IRQ_MASK);
  assign rd_timer_high = req.rd && hit(req.addr, speed_meas_pkg::ADDR_TIMER_HIGH);
  assign rd_cap_high   = req.rd && hit(req.addr, speed_meas_pkg::ADDR_CAP_HIGH);
  assign rd_cap_low    = req.rd && hit(req.addr, speed_meas_pkg::ADDR_CAP_LOW);

  // mode decode from control bits
  assign clock_enable           = ctrl_a_q[speed_meas_pkg::BIT_CLK_EN];
  assign sensor_type_select     = ctrl_b_q[speed_meas_pkg::BIT_SENS_HI:speed_meas_pkg::BIT_SENS_LO];
  assign auto_switch_select     = ctrl_b_q[speed_meas_pkg::BIT_AUTO_SW];
  assign edge_direction_bit     = ctrl_b_q[speed_meas_pkg::BIT_EDGE_DIR];
  assign encoder_capture_select = zero_filt_q[speed_meas_pkg::BIT_ENC_CAP];
  assign mode = !clock_enable ? speed_meas_pkg::MODE_CFG
              : (sensor_type_select != speed_meas_pkg::SENS_NONE) ? speed_meas_pkg::MODE_SPEED
              : auto_switch_select ? speed_meas_pkg::MODE_AUTO
              : speed_meas_pkg::MODE_SWITCHED;
  assign speed_mode = (mode == speed_meas_pkg::MODE_SPEED);
  assign is_encoder = (sensor_type_select == speed_meas_pkg::SENS_ENC);

  // ==========================================================
  // count source and capture source
  assign src_pulse = is_encoder ? encoder_pulse : 1'b1;

  prescale_div prescale_div_i (
    .clk       (clk),
    .rst       (rst),
    .src_pulse (src_pulse),
    .run       (speed_mode),
    .prescale  (st_q),
    .tick      (tick)
  );

  capture_src capture_src_i (
    .clk                    (clk),
    .rst                    (rst),
    .tacho_in               (tacho_in),
    .rtc_pulse              (rtc_pulse),
    .timer_high_rd          (rd_timer_high),
    .sensor_type_select     (sensor_type_select),
    .edge_direction_bit     (edge_direction_bit),
    .encoder_capture_select (encoder_capture_select),
    .cap_evt                (cap_evt)
  );

  // a capture while the low byte is locked is dropped
  assign cap_take = speed_mode && cap_evt && !lock_q;

  // speed error limit is compare byte over a fixed FF low byte
  assign err_limit     = {speed_cmp_q, speed_meas_pkg::CMP_LOW};
  assign speed_err_hit = speed_mode && (cnt_q > err_limit);

  // ==========================================================
  // counter and prescaler next state
  // left shift of the freshly cleared count
  function automatic speed_meas_pkg::count_t count_t_shl(input speed_meas_pkg::count_t v);
    count_t_shl = {v[14:0], 1'b0};
  endfunction : count_t_shl

  // counter and prescaler update
  always_comb
  begin
    cnt_d    = cnt_q;
    st_d     = st_q;
    up_set   = 1'b0;
    down_set = 1'b0;
    unique case (mode)
      speed_meas_pkg::MODE_CFG:
      begin
        if (wr_timer_high)
          cnt_d[15:8] = req.wdata;
        if (wr_timer_low)
          cnt_d[7:0] = req.wdata;
        if (wr_prescale)
          st_d = req.wdata[3:0];
      end
      speed_meas_pkg::MODE_SWITCHED:
      begin
        if (wr_status && req.wdata[speed_meas_pkg::BIT_RATIO_DN]
            && st_q != speed_meas_pkg::PRESCALE_MIN)
          st_d = st_q - 4'h1;
        else if (wr_status && req.wdata[speed_meas_pkg::BIT_RATIO_UP]
                 && st_q != speed_meas_pkg::PRESCALE_MAX)
          st_d = st_q + 4'h1;
      end
      speed_meas_pkg::MODE_AUTO:
      begin
        st_d = st_q;
      end
      speed_meas_pkg::MODE_SPEED:
      begin
        // counting is always upward, whatever the edge direction bit
        if (cap_take)
        begin
          cnt_d = speed_meas_pkg::COUNT_RST;
          if (cnt_q < speed_meas_pkg::COUNT_LOW
              && st_q != speed_meas_pkg::PRESCALE_MIN)
          begin
            st_d     = st_q - 4'h1;
            cnt_d    = count_t_shl(speed_meas_pkg::COUNT_RST);
            down_set = 1'b1;
          end
        end
        else if (tick)
        begin
          if (cnt_q != speed_meas_pkg::COUNT_MAX)
            cnt_d = cnt_q + 16'h0001;
          else if (st_q != speed_meas_pkg::PRESCALE_MAX)
          begin
            st_d   = st_q + 4'h1;
            cnt_d  = cnt_q >> 1;
            up_set = 1'b1;
          end
          else
            cnt_d = cnt_q;
        end
      end
    endcase
  end

  // capture register: hardware copy, else software write
  always_comb
  begin
    cap_d = cap_q;
    if (cap_take)
      cap_d = cnt_q;
    else
    begin
      if (wr_cap_high)
        cap_d[15:8] = req.wdata;
      if (wr_cap_low)
        cap_d[7:0] = req.wdata;
    end
  end

  // low byte lock between the two capture reads
  assign lock_d = !speed_mode ? 1'b0 : rd_cap_low ? 1'b0 : rd_cap_high ? 1'b1 : lock_q;

  // ==========================================================
  // flags: hardware set wins over software clear
  assign clr_bits = wr_status ? ~req.wdata[4:0] : 5'h00;
  always_comb
  begin
    flags_d = flags_q;
    if (mode != speed_meas_pkg::MODE_SWITCHED)
    begin
      flags_d.ratio_down = flags_q.ratio_down && !clr_bits[0];
      flags_d.ratio_up   = flags_q.ratio_up && !clr_bits[1];
    end
    flags_d.ratio_down = flags_d.ratio_down || down_set;
    flags_d.ratio_up   = flags_d.ratio_up || up_set;
    flags_d.capture    = (flags_q.capture && !clr_bits[2]) || cap_take;
    flags_d.speed_err  = (flags_q.speed_err && !clr_bits[3]) || speed_err_hit;
    flags_d.emerg      = (flags_q.emerg && !clr_bits[4]) || emergency_stop_input;
  end

  // interrupt requests, each under its own mask
  assign ratio_irq   = mask_q.ratio && (flags_q.ratio_up || flags_q.ratio_down);
  assign capture_irq = mask_q.capture && flags_q.capture;
  assign safety_irq  = (mask_q.speed_err && flags_q.speed_err)
                    || (mask_q.emerg && flags_q.emerg);

  // ==========================================================
  // read data selection
  assign rd_mux = hit(req.addr, speed_meas_pkg::ADDR_TIMER_HIGH) ? cnt_q[15:8]
                : hit(req.addr, speed_meas_pkg::ADDR_TIMER_LOW)  ? cnt_q[7:0]
                : hit(req.addr, speed_meas_pkg::ADDR_CAP_HIGH)   ? cap_q[15:8]
                : hit(req.addr, speed_meas_pkg::ADDR_CAP_LOW)    ? cap_q[7:0]
                : hit(req.addr, speed_meas_pkg::ADDR_COMM_CMP)   ? comm_cmp_q
                : hit(req.addr, speed_meas_pkg::ADDR_SPEED_CMP)  ? speed_cmp_q
                : hit(req.addr, speed_meas_pkg::ADDR_PRESCALE)   ? {4'h0, st_q}
                : hit(req.addr, speed_meas_pkg::ADDR_CTRL_A)     ? ctrl_a_q
                : hit(req.addr, speed_meas_pkg::ADDR_CTRL_B)     ? ctrl_b_q
                : hit(req.addr, speed_meas_pkg::ADDR_ZERO_FILT)  ? zero_filt_q
                : hit(req.addr, speed_meas_pkg::ADDR_IRQ_STATUS) ? {3'h0, flags_q}
                : hit(req.addr, speed_meas_pkg::ADDR_IRQ_MASK)   ? {4'h0, mask_q}
                : 8'h00;
  assign rdata = rdata_q;

  // ==========================================================
  // timer state registers; counter, prescaler and capture also move without a bus write
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      cnt_q  <= speed_meas_pkg::COUNT_RST;
      st_q   <= speed_meas_pkg::PRESCALE_MIN;
      cap_q  <= speed_meas_pkg::COUNT_RST;
      lock_q <= 1'b0;
    end
    else
    begin
      cnt_q  <= cnt_d;
      st_q   <= st_d;
      cap_q  <= cap_d;
      lock_q <= lock_d;
    end
  end

  // software-owned configuration registers
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      comm_cmp_q  <= speed_meas_pkg::BYTE_RST;
      speed_cmp_q <= speed_meas_pkg::BYTE_RST;
      ctrl_a_q    <= speed_meas_pkg::BYTE_RST;
      ctrl_b_q    <= speed_meas_pkg::BYTE_RST;
      zero_filt_q <= speed_meas_pkg::BYTE_RST;
    end
    else
    begin
      if (wr_comm && !speed_mode)
        comm_cmp_q <= req.wdata;
      if (wr_speed)
        speed_cmp_q <= req.wdata;
      if (wr_ctrl_a)
        ctrl_a_q <= req.wdata;
      if (wr_ctrl_b)
        ctrl_b_q <= req.wdata;
      if (wr_zero)
        zero_filt_q <= req.wdata;
    end
  end

  // flags, masks and read data
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      flags_q <= '0;
      mask_q  <= '0;
      rdata_q <= speed_meas_pkg::BYTE_RST;
    end
    else
    begin
      flags_q <= flags_d;
      if (wr_mask)
        mask_q <= req.wdata[3:0];
      rdata_q <= req.rd ? rd_mux : speed_meas_pkg::BYTE_RST;
    end
  end

  // ==========================================================
  // checks
  sequence s_overflow;
    speed_mode && tick && !cap_take && cnt_q == speed_meas_pkg::COUNT_MAX;
  endsequence

  chk_cfg_timer_write: assert property (@(posedge clk) disable iff (rst)
    mode == speed_meas_pkg::MODE_CFG && wr_timer_high |=> cnt_q[15:8] == $past(req.wdata))
    else $error("timer high byte not written in configuration mode");
  chk_switched_step: assert property (@(posedge clk) disable iff (rst)
    mode == speed_meas_pkg::MODE_SWITCHED && wr_status && req.wdata[1] && !req.wdata[0]
    && st_q != speed_meas_pkg::PRESCALE_MAX |=> st_q == $past(st_q) + 4'h1)
    else $error("switched mode up command did not step prescaler");
  chk_speed_ro_prescale: assert property (@(posedge clk) disable iff (rst)
    speed_mode && wr_prescale && !tick && !cap_take |=> $stable(st_q))
    else $error("prescaler written in speed mode");
  chk_capture_clear: assert property (@(posedge clk) disable iff (rst)
    cap_take |=> cnt_q == speed_meas_pkg::COUNT_RST && cap_q == $past(cnt_q))
    else $error("capture did not copy and clear counter");
  chk_lock_low: assert property (@(posedge clk) disable iff (rst)
    lock_q && !wr_cap_low |=> $stable(cap_q[7:0]))
    else $error("locked capture low byte changed");
  chk_speed_error: assert property (@(posedge clk) disable iff (rst)
    speed_mode && cnt_q > {speed_cmp_q, speed_meas_pkg::CMP_LOW} |=> flags_q.speed_err)
    else $error("speed error flag missing");
  chk_overflow_up: assert property (@(posedge clk) disable iff (rst)
    s_overflow ##0 st_q != speed_meas_pkg::PRESCALE_MAX
    |=> st_q == $past(st_q) + 4'h1 && cnt_q == (speed_meas_pkg::COUNT_MAX >> 1) && flags_q.ratio_up)
    else $error("overflow did not raise prescaler");
  chk_stall_max: assert property (@(posedge clk) disable iff (rst)
    s_overflow ##0 st_q == speed_meas_pkg::PRESCALE_MAX
    |=> cnt_q == speed_meas_pkg::COUNT_MAX && st_q == speed_meas_pkg::PRESCALE_MAX)
    else $error("counter did not stall at top prescale");
  chk_low_capture: assert property (@(posedge clk) disable iff (rst)
    cap_take && cnt_q < speed_meas_pkg::COUNT_LOW && st_q != speed_meas_pkg::PRESCALE_MIN
    |=> st_q == $past(st_q) - 4'h1 && flags_q.ratio_down)
    else $error("low capture did not lower prescaler");
  chk_read_data: assert property (@(posedge clk) disable iff (rst)
    req.rd |=> rdata == $past(rd_mux))
    else $error("read data not presented one cycle later");

endmodule : speed_meas_timer
`default_nettype wire

/* File: tb/sensor_model.sv */
// sensor model: tacho square wave and encoder count pulses
`timescale 1ns/1ns
`default_nettype none
module sensor_model (
  // clock and controls
  input  wire logic        clk,
  input  wire logic        run,
  input  wire logic [11:0] half,
  // sensor lines
  output wire logic        tacho_in,
  output wire logic        encoder_pulse
);
  logic [11:0] cnt_q   = 12'h000;
  logic        tacho_q = 1'b0;
  logic        pulse_q = 1'b0;
  // one driver per line
  assign tacho_in      = tacho_q;
  assign encoder_pulse = pulse_q;
  // tacho toggles each half period, encoder pulses every fourth clock
  always @(posedge clk)
  begin
    cnt_q <= (!run || cnt_q == half) ? 12'h000 : cnt_q + 12'h001;
    if (run && cnt_q == half)
      tacho_q <= !tacho_q;
    pulse_q <= run && cnt_q[1:0] == 2'h3;
  end
endmodule : sensor_model
`default_nettype wire

/* File: tb/tb_top.sv */
// bench for the speed measurement timer
`timescale 1ns/1ns
`default_nettype none
module tb_top;
  logic                     clk, rst, run, rtc, estop, tacho_in, encoder_pulse;
  logic                     ratio_irq, capture_irq, safety_irq;
  logic [11:0]              half;
  logic [7:0]               rdata;
  speed_meas_pkg::bus_req_s req;
  int                       err_total, samples_checked;
  speed_meas_timer speed_meas_timer_i (.clk(clk), .rst(rst), .req(req), .rdata(rdata),
    .tacho_in(tacho_in), .encoder_pulse(encoder_pulse), .rtc_pulse(rtc),
    .emergency_stop_input(estop), .ratio_irq(ratio_irq), .capture_irq(capture_irq),
    .safety_irq(safety_irq));
  sensor_model sensor_model_i (.clk(clk), .run(run), .half(half), .tacho_in(tacho_in),
    .encoder_pulse(encoder_pulse));
  initial
  begin
    clk = 1'b0;
    forever #20 clk = !clk;
  end
  // range compare, exact when lo equals hi
  task automatic chk(input string n, input logic [7:0] lo, hi, s);
    samples_checked++;
    if ((s >= lo && s <= hi) !== 1'b1)
    begin
      err_total++;
      $display("unexpected %s expected %h..%h seen %h", n, lo, hi, s);
    end
  endtask : chk
  task automatic wr(input speed_meas_pkg::addr_t a, input logic [7:0] d);
    @(posedge clk);
    req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    @(posedge clk);
    req.wr <= 1'b0;
  endtask : wr
  task automatic rd(input speed_meas_pkg::addr_t a, input logic [7:0] lo, hi, input string n);
    @(posedge clk);
    req <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
    @(posedge clk);
    req.rd <= 1'b0;
    #1 chk(n, lo, hi, rdata);
  endtask : rd
  // stop clock, clear flags, load timer and prescale, then enable
  task automatic cfg(input logic [7:0] ctl_b, pre, th, tl);
    wr(4'h7, 8'h00);
    wr(4'ha, 8'h00);
    wr(4'h0, th);
    wr(4'h1, tl);
    wr(4'h6, pre);
    wr(4'h8, ctl_b);
    wr(4'h7, 8'h01);
  endtask : cfg
  task automatic t_config;
    wr(4'h0, 8'ha5);
    rd(4'h0, 8'ha5, 8'ha5, "timer_high");
    wr(4'h5, 8'h3c);
    rd(4'h5, 8'h3c, 8'h3c, "speed_cmp");
    rd(4'hc, 8'h00, 8'h00, "unmapped");
  endtask : t_config
  task automatic t_tacho;
    run = 1'b1;
    cfg(8'h01, 8'h00, 8'h00, 8'h00);
    wr(4'h5, 8'h00);
    wr(4'hb, 8'h06);
    repeat (2400) @(posedge clk);
    rd(4'ha, 8'h0c, 8'h0c, "status");
    chk("capture_irq", 8'h01, 8'h01, {7'h00, capture_irq});
    chk("safety_irq", 8'h01, 8'h01, {7'h00, safety_irq});
    chk("ratio_irq", 8'h00, 8'h00, {7'h00, ratio_irq});
    rd(4'h2, 8'h03, 8'h03, "cap_high");
    half = 12'h260;
    repeat (2400) @(posedge clk);
    rd(4'h3, 8'h7e, 8'h82, "cap_low");
  endtask : t_tacho
  task automatic t_ovf;
    run = 1'b0;
    wr(4'h5, 8'hff);
    cfg(8'h01, 8'h00, 8'hff, 8'hf0);
    wr(4'hb, 8'h01);
    repeat (40) @(posedge clk);
    rd(4'h6, 8'h01, 8'h01, "prescale");
    rd(4'ha, 8'h02, 8'h02, "status");
    chk("ratio_irq", 8'h01, 8'h01, {7'h00, ratio_irq});
    wr(4'h0, 8'h12);
    wr(4'h6, 8'h05);
    rd(4'h0, 8'h7f, 8'h80, "timer_high");
    rd(4'h6, 8'h01, 8'h01, "prescale");
    rd(4'h5, 8'hff, 8'hff, "speed_cmp");
    wr(4'ha, 8'h1d);
    rd(4'ha, 8'h00, 8'h00, "status");
  endtask : t_ovf
  // top prescale: counter holds at its maximum, nothing else moves
  task automatic t_stall;
    run = 1'b0;
    cfg(8'h01, 8'h0f, 8'hff, 8'hff);
    repeat (32800) @(posedge clk);
    rd(4'h0, 8'hff, 8'hff, "timer_high");
    rd(4'h1, 8'hff, 8'hff, "timer_low");
    rd(4'h6, 8'h0f, 8'h0f, "prescale");
    rd(4'ha, 8'h00, 8'h00, "status");
  endtask : t_stall
  task automatic t_modes;
    cfg(8'h00, 8'h03, 8'h00, 8'h00);
    wr(4'ha, 8'h02);
    rd(4'h6, 8'h04, 8'h04, "prescale");
    wr(4'ha, 8'h01);
    wr(4'h6, 8'h09);
    rd(4'h6, 8'h03, 8'h03, "prescale");
    cfg(8'h04, 8'h03, 8'h00, 8'h00);
    wr(4'h6, 8'h09);
    rd(4'h6, 8'h03, 8'h03, "prescale");
  endtask : t_modes
  // emergency stop sets its own flag on the safety channel
  task automatic t_estop;
    wr(4'hb, 8'h08);
    estop <= 1'b1;
    @(posedge clk);
    estop <= 1'b0;
    rd(4'ha, 8'h10, 8'h10, "status");
    chk("safety_irq", 8'h01, 8'h01, {7'h00, safety_irq});
    wr(4'ha, 8'h0f);
    rd(4'ha, 8'h00, 8'h00, "status");
    chk("safety_irq", 8'h00, 8'h00, {7'h00, safety_irq});
  endtask : t_estop
  task automatic t_enc;
    half = 12'hfff;
    run = 1'b1;
    cfg(8'h0b, 8'h01, 8'h00, 8'h00);
    wr(4'h9, 8'h01);
    repeat (400) @(posedge clk);
    rd(4'h0, 8'h00, 8'h00, "timer_high");
    rd(4'h3, 8'h30, 8'h34, "cap_low");
    rd(4'ha, 8'h05, 8'h05, "status");
    rd(4'h6, 8'h00, 8'h00, "prescale");
    wr(4'h9, 8'h00);
    repeat (200) @(posedge clk);
    rtc <= 1'b1;
    @(posedge clk);
    rtc <= 1'b0;
    rd(4'h3, 8'h32, 8'h36, "cap_low_rtc");
  endtask : t_enc
  task automatic end_of_test;
    if (err_total == 0 && samples_checked > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask : end_of_test
  initial
  begin
    rst = 1'b1;
    run = 1'b0;
    rtc = 1'b0;
    estop = 1'b0;
    half = 12'h1c0;
    req = '0;
    err_total = 0;
    samples_checked = 0;
    repeat (20) @(posedge clk);
    rst <= 1'b0;
    t_config();
    t_tacho();
    t_ovf();
    t_stall();
    t_modes();
    t_estop();
    t_enc();
    end_of_test();
  end
  // hang guard well beyond the expected run length
  initial
  begin
    repeat (60000) @(posedge clk);
    err_total++;
    end_of_test();
  end
endmodule : tb_top
`default_nettype wire
